// file: psbel_defines.svh
// Functional notes
// - Sample block input once per processing cycle.
// - Pick-up while unblocked asserts start, begins timing.
// - Pick-up while stage_a asserts stage_a, nothing else.
// - Block during start behaves as pick-up release.
// - Blocking raises display notice and blocking event.
// - Stage forcing mode selects software block switch.
// - Event on every edge of three outputs.
// - Per-event mask selects stored ON/OFF transitions.
// - Events carry time stamp and process data.
// - Shared event block, six codes per stage.
// - History keeps twelve most recent records.
// - History written only on ON transitions.
// - Record: time, event, magnitude, ratio, remaining, group.
`ifndef PSBEL_DEFINES_SVH
`define PSBEL_DEFINES_SVH

`define PSBEL_CLK_MHZ        100
`define PSBEL_CYCLE_US       1000
`define PSBEL_CYCLE_CNT      (`PSBEL_CYCLE_US * `PSBEL_CLK_MHZ)
`define PSBEL_BLK_LEAD_MS    5

`define PSBEL_ADDR_W         8
`define PSBEL_REG_CTRL       8'h00
`define PSBEL_REG_OP_DLY     8'h04
`define PSBEL_REG_REL_DLY    8'h08
`define PSBEL_REG_EVT_MASK   8'h0c
`define PSBEL_REG_STATUS     8'h10
`define PSBEL_REG_IRQ_STAT   8'h14
`define PSBEL_REG_IRQ_EN     8'h18
`define PSBEL_REG_IRQ_CLR    8'h1c
`define PSBEL_REG_HIST_SEL   8'h20
`define PSBEL_REG_HIST_W0    8'h24
`define PSBEL_REG_HIST_W1    8'h28
`define PSBEL_REG_HIST_W2    8'h2c
`define PSBEL_REG_HIST_W3    8'h30
`define PSBEL_REG_HIST_W4    8'h34

`define PSBEL_OP_DLY_RST     21'h000028
`define PSBEL_REL_DLY_RST    21'h00003c
`define PSBEL_DLY_MAX        21'h1b7740
`define PSBEL_EVT_MASK_RST   6'h3f

`define PSBEL_EV_START_ON    0
`define PSBEL_EV_START_OFF   1
`define PSBEL_EV_TRIP_ON     2
`define PSBEL_EV_TRIP_OFF    3
`define PSBEL_EV_BLK_ON      4
`define PSBEL_EV_BLK_OFF     5
`define PSBEL_EV_PER_STAGE   6
`define PSBEL_EV_RSV_AFTER   5
`define PSBEL_EV_RSV_CNT     2

`define PSBEL_HIST_DEPTH     12
`define PSBEL_TIME_W         40
`define PSBEL_CODE_W         7
`define PSBEL_VAL_W          32
`define PSBEL_REM_W          21
`define PSBEL_SG_W           3
`define PSBEL_FAULT_W        4
`define PSBEL_REC_W          135

`endif

// file: psbel_pkg.sv
package psbel_pkg;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_START   = 5'h02,
    ST_TRIP    = 5'h04,
    ST_STAGE_A = 5'h08,
    ST_RELEASE = 5'h10
  } psbel_state_t;

endpackage : psbel_pkg

// file: psbel_hist_mem.sv
`timescale 1ns/100ps
`include "psbel_defines.svh"

module psbel_hist_mem (
  // Clock
  input  wire logic                    sys_clk_i,
  // Write side
  input  wire logic                    wr_en_i,
  input  wire logic [3:0]              wr_addr_i,
  input  wire logic [`PSBEL_REC_W-1:0] wr_data_i,
  // Read side
  input  wire logic [3:0]              rd_addr_i,
  output logic      [`PSBEL_REC_W-1:0] rd_data_o
);

  logic [`PSBEL_REC_W-1:0] mem_r [`PSBEL_HIST_DEPTH];

  always_ff @(posedge sys_clk_i) begin
    if (wr_en_i) begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    rd_data_o <= mem_r[rd_addr_i];
  end

endmodule : psbel_hist_mem

// file: psbel_top.sv
`timescale 1ns/100ps
`include "psbel_defines.svh"

module psbel_top #(
  parameter int CYCLE_CNT = `PSBEL_CYCLE_CNT,
  parameter int STAGE_IDX = 0
) (
  // Clock and reset
  input  wire logic                      sys_clk_i,
  input  wire logic                      srst_i,
  // Stage inputs
  input  wire logic                      pickup_i,
  input  wire logic                      block_i,
  input  wire logic                      stage_forcing_enable_i,
  // Process data
  input  wire logic [`PSBEL_TIME_W-1:0]  time_ms_i,
  input  wire logic [`PSBEL_VAL_W-1:0]   meas_mag_i,
  input  wire logic [`PSBEL_VAL_W-1:0]   mag_ratio_i,
  input  wire logic [`PSBEL_FAULT_W-1:0] fault_type_i,
  input  wire logic [`PSBEL_SG_W-1:0]    active_setting_group_i,
  // Stage status
  output logic                           stage_start_o,
  output logic                           stage_trip_o,
  output logic                           stage_a_o,
  output logic                           hmi_block_o,
  // Event stream to the main event buffer
  output logic                           evt_valid_o,
  output logic [`PSBEL_CODE_W-1:0]       evt_code_o,
  output logic [`PSBEL_TIME_W-1:0]       evt_time_o,
  output logic [`PSBEL_VAL_W-1:0]        evt_mag_o,
  output logic [`PSBEL_VAL_W-1:0]        evt_ratio_o,
  output logic [`PSBEL_FAULT_W-1:0]      evt_fault_o,
  output logic [`PSBEL_SG_W-1:0]         evt_sg_o,
  // Register port
  input  wire logic [`PSBEL_ADDR_W-1:0]  reg_addr_i,
  input  wire logic [31:0]               reg_wdata_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  output logic      [31:0]               reg_rdata_o,
  // Interrupt
  output logic                           irq_o
);

  localparam int BASE_I = STAGE_IDX * `PSBEL_EV_PER_STAGE
                        + ((STAGE_IDX >= `PSBEL_EV_RSV_AFTER) ? `PSBEL_EV_RSV_CNT : 0);
  localparam logic [`PSBEL_CODE_W-1:0] CODE_BASE = BASE_I[`PSBEL_CODE_W-1:0];
  localparam logic [3:0] LAST_SLOT = 4'(`PSBEL_HIST_DEPTH - 1);
  localparam logic [3:0] DEPTH4 = 4'(`PSBEL_HIST_DEPTH);

  psbel_pkg::psbel_state_t state_r;
  psbel_pkg::psbel_state_t state_nxt;

  logic [31:0]              div_r;
  logic                     tick_r;
  logic                     step_r;
  logic                     blk_s_r;
  logic                     pick_s_r;
  logic                     sw_block_r;
  logic [`PSBEL_REM_W-1:0]  op_dly_r;
  logic [`PSBEL_REM_W-1:0]  rel_dly_r;
  logic [5:0]               evt_mask_r;
  logic [`PSBEL_REM_W-1:0]  op_tmr_r;
  logic [`PSBEL_REM_W-1:0]  op_tmr_nxt;
  logic [`PSBEL_REM_W-1:0]  rel_tmr_r;
  logic [`PSBEL_REM_W-1:0]  rel_tmr_nxt;
  logic [5:0]               pend_r;
  logic [5:0]               edges;
  logic [2:0]               ev_idx;
  logic                     ev_any;
  logic [`PSBEL_TIME_W-1:0] snap_time_r;
  logic [`PSBEL_VAL_W-1:0]  snap_mag_r;
  logic [`PSBEL_VAL_W-1:0]  snap_ratio_r;
  logic [`PSBEL_FAULT_W-1:0] snap_fault_r;
  logic [`PSBEL_SG_W-1:0]   snap_sg_r;
  logic [`PSBEL_REM_W-1:0]  snap_rem_r;
  logic                     hist_we;
  logic [3:0]               wptr_r;
  logic [3:0]               hcnt_r;
  logic [3:0]               hsel_r;
  logic [3:0]               hrd_addr;
  logic [4:0]               hsum;
  logic [`PSBEL_REC_W-1:0]  hist_wdata;
  logic [`PSBEL_REC_W-1:0]  hist_rdata;
  logic [2:0]               irq_stat_r;
  logic [2:0]               irq_en_r;
  logic                     start_nxt;
  logic                     trip_nxt;
  logic                     a_nxt;

  // Processing cycle divider; the first cycle of each period samples the inputs.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      div_r  <= 32'h0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (div_r == 32'(CYCLE_CNT - 1));
      div_r  <= (div_r == 32'(CYCLE_CNT - 1)) ? 32'h0 : div_r + 32'h1;
    end
  end

  // Decisions run one clock after sampling so they only ever see the held value.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      blk_s_r  <= 1'b0;
      pick_s_r <= 1'b0;
      step_r   <= 1'b0;
    end else begin
      step_r <= tick_r;
      if (tick_r) begin
        blk_s_r  <= stage_forcing_enable_i ? sw_block_r : block_i;
        pick_s_r <= pickup_i;
      end
    end
  end

  // The operate timer is kept through release so a returning pick-up resumes it.
  always_comb begin
    state_nxt   = state_r;
    op_tmr_nxt  = op_tmr_r;
    rel_tmr_nxt = rel_tmr_r;
    case (state_r)
      psbel_pkg::ST_IDLE: begin
        op_tmr_nxt  = '0;
        rel_tmr_nxt = '0;
        if (pick_s_r && blk_s_r) begin
          state_nxt = psbel_pkg::ST_STAGE_A;
        end else if (pick_s_r) begin
          state_nxt = psbel_pkg::ST_START;
        end
      end
      psbel_pkg::ST_START: begin
        if (blk_s_r || !pick_s_r) begin
          state_nxt   = psbel_pkg::ST_RELEASE;
          rel_tmr_nxt = '0;
        end else if (op_tmr_r + 21'h1 >= op_dly_r) begin
          state_nxt  = psbel_pkg::ST_TRIP;
          op_tmr_nxt = op_dly_r;
        end else begin
          op_tmr_nxt = op_tmr_r + 21'h1;
        end
      end
      psbel_pkg::ST_TRIP: begin
        if (blk_s_r || !pick_s_r) begin
          state_nxt   = psbel_pkg::ST_RELEASE;
          rel_tmr_nxt = '0;
        end
      end
      psbel_pkg::ST_RELEASE: begin
        if (pick_s_r && !blk_s_r) begin
          state_nxt = psbel_pkg::ST_START;
        end else if (rel_tmr_r + 21'h1 >= rel_dly_r) begin
          state_nxt  = (pick_s_r && blk_s_r) ? psbel_pkg::ST_STAGE_A : psbel_pkg::ST_IDLE;
          op_tmr_nxt = '0;
        end else begin
          rel_tmr_nxt = rel_tmr_r + 21'h1;
        end
      end
      psbel_pkg::ST_STAGE_A: begin
        if (!pick_s_r) begin
          state_nxt = psbel_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = psbel_pkg::ST_IDLE;
      end
    endcase
  end

  assign start_nxt = (state_nxt == psbel_pkg::ST_START);
  assign trip_nxt  = (state_nxt == psbel_pkg::ST_TRIP);
  assign a_nxt     = (state_nxt == psbel_pkg::ST_STAGE_A);
  assign edges = {stage_a_o & ~a_nxt, ~stage_a_o & a_nxt,
                  stage_trip_o & ~trip_nxt, ~stage_trip_o & trip_nxt,
                  stage_start_o & ~start_nxt, ~stage_start_o & start_nxt};

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_r       <= psbel_pkg::ST_IDLE;
      op_tmr_r      <= '0;
      rel_tmr_r     <= '0;
      stage_start_o <= 1'b0;
      stage_trip_o  <= 1'b0;
      stage_a_o     <= 1'b0;
      hmi_block_o   <= 1'b0;
    end else begin
      hmi_block_o <= step_r & edges[`PSBEL_EV_BLK_ON];
      if (step_r) begin
        state_r       <= state_nxt;
        op_tmr_r      <= op_tmr_nxt;
        rel_tmr_r     <= rel_tmr_nxt;
        stage_start_o <= start_nxt;
        stage_trip_o  <= trip_nxt;
        stage_a_o     <= a_nxt;
      end
    end
  end

  // Process data are frozen at the transition; queued events drain in the next cycles.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      snap_time_r  <= '0;
      snap_mag_r   <= '0;
      snap_ratio_r <= '0;
      snap_fault_r <= '0;
      snap_sg_r    <= '0;
      snap_rem_r   <= '0;
    end else if (step_r && (edges != 6'h0)) begin
      snap_time_r  <= time_ms_i;
      snap_mag_r   <= meas_mag_i;
      snap_ratio_r <= mag_ratio_i;
      snap_fault_r <= fault_type_i;
      snap_sg_r    <= active_setting_group_i;
      snap_rem_r   <= start_nxt ? op_dly_r - op_tmr_nxt : '0;
    end
  end

  always_comb begin
    ev_idx = 3'h0;
    ev_any = 1'b0;
    for (int k = `PSBEL_EV_PER_STAGE - 1; k >= 0; k--) begin
      if (pend_r[k]) begin
        ev_idx = 3'(k);
        ev_any = 1'b1;
      end
    end
  end

  // Two transitions at most per processing cycle, so the queue always empties in time.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pend_r      <= 6'h0;
      evt_valid_o <= 1'b0;
      evt_code_o  <= '0;
      evt_time_o  <= '0;
      evt_mag_o   <= '0;
      evt_ratio_o <= '0;
      evt_fault_o <= '0;
      evt_sg_o    <= '0;
    end else begin
      if (step_r) begin
        pend_r <= edges;
      end else if (ev_any) begin
        pend_r[ev_idx] <= 1'b0;
      end
      evt_valid_o <= !step_r && ev_any && evt_mask_r[ev_idx];
      evt_code_o  <= CODE_BASE + {4'h0, ev_idx};
      evt_time_o  <= snap_time_r;
      evt_mag_o   <= snap_mag_r;
      evt_ratio_o <= snap_ratio_r;
      evt_fault_o <= snap_fault_r;
      evt_sg_o    <= snap_sg_r;
    end
  end

  // History takes every ON transition whatever the event mask says.
  assign hist_we    = !step_r && ev_any && !ev_idx[0];
  assign hist_wdata = {snap_time_r, CODE_BASE + {4'h0, ev_idx}, snap_mag_r,
                       snap_ratio_r, snap_rem_r, snap_sg_r};

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wptr_r <= 4'h0;
      hcnt_r <= 4'h0;
    end else if (hist_we) begin
      wptr_r <= (wptr_r == LAST_SLOT) ? 4'h0 : wptr_r + 4'h1;
      if (hcnt_r != DEPTH4) begin
        hcnt_r <= hcnt_r + 4'h1;
      end
    end
  end

  // Slot 0 of the selector is always the oldest record held.
  assign hsum     = {1'b0, wptr_r} + {1'b0, hsel_r};
  assign hrd_addr = (hcnt_r != DEPTH4) ? hsel_r :
                    (hsum >= 5'(`PSBEL_HIST_DEPTH)) ? 4'(hsum - 5'(`PSBEL_HIST_DEPTH)) :
                    hsum[3:0];

  psbel_hist_mem u_hist (
    .sys_clk_i (sys_clk_i),
    .wr_en_i   (hist_we),
    .wr_addr_i (wptr_r),
    .wr_data_i (hist_wdata),
    .rd_addr_i (hrd_addr),
    .rd_data_o (hist_rdata)
  );

  // Configuration registers.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sw_block_r <= 1'b0;
      op_dly_r   <= `PSBEL_OP_DLY_RST;
      rel_dly_r  <= `PSBEL_REL_DLY_RST;
      evt_mask_r <= `PSBEL_EVT_MASK_RST;
      irq_en_r   <= 3'h0;
      hsel_r     <= 4'h0;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `PSBEL_REG_CTRL:     sw_block_r <= reg_wdata_i[0];
        `PSBEL_REG_OP_DLY:   op_dly_r   <= (reg_wdata_i[20:0] > `PSBEL_DLY_MAX) ?
                                           `PSBEL_DLY_MAX : reg_wdata_i[20:0];
        `PSBEL_REG_REL_DLY:  rel_dly_r  <= (reg_wdata_i[20:0] > `PSBEL_DLY_MAX) ?
                                           `PSBEL_DLY_MAX : reg_wdata_i[20:0];
        `PSBEL_REG_EVT_MASK: evt_mask_r <= reg_wdata_i[5:0];
        `PSBEL_REG_IRQ_EN:   irq_en_r   <= reg_wdata_i[2:0];
        `PSBEL_REG_HIST_SEL: hsel_r     <= (reg_wdata_i[3:0] > LAST_SLOT) ?
                                           LAST_SLOT : reg_wdata_i[3:0];
        default: begin
        end
      endcase
    end
  end

  // Sticky interrupt flags; a new event beats a clear in the same cycle.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      irq_stat_r <= 3'h0;
      irq_o      <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~((reg_wr_i && reg_addr_i == `PSBEL_REG_IRQ_CLR) ?
                                    reg_wdata_i[2:0] : 3'h0))
                  | ({3{step_r}} & {edges[`PSBEL_EV_BLK_ON], edges[`PSBEL_EV_TRIP_ON],
                                    edges[`PSBEL_EV_START_ON]});
      irq_o <= |(irq_stat_r & irq_en_r);
    end
  end

  // Read data stand in the cycle after the strobe only.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 32'h0;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= 32'h0;
    end else begin
      case (reg_addr_i)
        `PSBEL_REG_CTRL:     reg_rdata_o <= {31'h0, sw_block_r};
        `PSBEL_REG_OP_DLY:   reg_rdata_o <= {11'h0, op_dly_r};
        `PSBEL_REG_REL_DLY:  reg_rdata_o <= {11'h0, rel_dly_r};
        `PSBEL_REG_EVT_MASK: reg_rdata_o <= {26'h0, evt_mask_r};
        `PSBEL_REG_STATUS:   reg_rdata_o <= {12'h0, hcnt_r, 5'h0, state_r, 1'b0,
                                             stage_forcing_enable_i, blk_s_r,
                                             stage_a_o, stage_trip_o, stage_start_o};
        `PSBEL_REG_IRQ_STAT: reg_rdata_o <= {29'h0, irq_stat_r};
        `PSBEL_REG_IRQ_EN:   reg_rdata_o <= {29'h0, irq_en_r};
        `PSBEL_REG_HIST_SEL: reg_rdata_o <= {28'h0, hsel_r};
        `PSBEL_REG_HIST_W0:  reg_rdata_o <= {8'h0, snap_or_rem(hist_rdata)};
        `PSBEL_REG_HIST_W1:  reg_rdata_o <= hist_rdata[55:24];
        `PSBEL_REG_HIST_W2:  reg_rdata_o <= hist_rdata[87:56];
        `PSBEL_REG_HIST_W3:  reg_rdata_o <= {25'h0, hist_rdata[94:88]};
        `PSBEL_REG_HIST_W4:  reg_rdata_o <= hist_rdata[126:95];
        default:             reg_rdata_o <= 32'h0;
      endcase
    end
  end

  // Word 0 packs remaining trip time above the setting group.
  function automatic logic [23:0] snap_or_rem(input logic [`PSBEL_REC_W-1:0] rec);
    snap_or_rem = rec[23:0];
  endfunction : snap_or_rem

endmodule : psbel_top

// file: psbel_sva.sv
`timescale 1ns/100ps
`include "psbel_defines.svh"

module psbel_sva #(
  parameter int CYCLE_CNT = 20,
  parameter int STAGE_IDX = 0
) (
  // Clock and reset
  input wire logic                     sys_clk_i,
  input wire logic                     srst_i,
  // Stage status
  input wire logic                     stage_start_o,
  input wire logic                     stage_trip_o,
  input wire logic                     stage_a_o,
  input wire logic                     hmi_block_o,
  // Events and register port
  input wire logic                     evt_valid_o,
  input wire logic [`PSBEL_CODE_W-1:0] evt_code_o,
  input wire logic                     reg_rd_i,
  input wire logic [31:0]              reg_rdata_o
);
  // Stages from the sixth on sit behind the two reserved codes.
  localparam int BASE = STAGE_IDX * 6 + ((STAGE_IDX >= 5) ? 2 : 0);

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  a_stage_a_excl: assert property (
    stage_a_o |-> !stage_start_o && !stage_trip_o)
    else $error("stage_a stage shows start or trip");
  a_block_via_release: assert property (
    $rose(stage_a_o) |-> !$past(stage_start_o) && !$past(stage_trip_o))
    else $error("stage_a state entered straight from start or trip");
  a_trip_from_start: assert property (
    $rose(stage_trip_o) |-> $past(stage_start_o))
    else $error("trip raised without a preceding start");
  a_notice_on_block: assert property (
    $rose(stage_a_o) |-> ##[0:1] hmi_block_o)
    else $error("no display notice on blocking");
  a_notice_pulse: assert property (
    hmi_block_o |=> !hmi_block_o)
    else $error("display notice longer than one cycle");
  a_out_steps: assert property (
    $changed({stage_start_o, stage_trip_o, stage_a_o}) |=>
      $stable({stage_start_o, stage_trip_o, stage_a_o})[*8])
    else $error("stage outputs changed between processing cycles");
  a_code_range: assert property (
    evt_valid_o |-> evt_code_o inside {[BASE:BASE + 5]})
    else $error("event code outside this stage's range");
  a_rdata_idle: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data without a read");

  c_trip: cover property ($rose(stage_trip_o));
  c_block: cover property ($rose(stage_a_o));
  c_event: cover property (evt_valid_o);
endmodule : psbel_sva

bind psbel_top psbel_sva #(.CYCLE_CNT(CYCLE_CNT), .STAGE_IDX(STAGE_IDX)) u_sva (
  .sys_clk_i, .srst_i, .stage_start_o, .stage_trip_o, .stage_a_o, .hmi_block_o,
  .evt_valid_o, .evt_code_o, .reg_rd_i, .reg_rdata_o);

// file: psbel_partner.sv
`timescale 1ns/100ps
`include "psbel_defines.svh"

module psbel_partner #(
  parameter int LAG = 2
) (
  // Clock and reset
  input  wire logic                      sys_clk_i,
  input  wire logic                      srst_i,
  // Blocking matrix
  input  wire logic                      blk_req_i,
  output logic                           block_o,
  // Event recorder
  input  wire logic                      evt_valid_i,
  input  wire logic [`PSBEL_CODE_W-1:0]  evt_code_i,
  input  wire logic [`PSBEL_TIME_W-1:0]  evt_time_i,
  input  wire logic [`PSBEL_FAULT_W-1:0] evt_fault_i,
  output logic [7:0]                     evt_cnt_o,
  output logic [`PSBEL_CODE_W-1:0]       last_code_o,
  output logic [`PSBEL_TIME_W-1:0]       last_time_o,
  output logic [`PSBEL_FAULT_W-1:0]      last_fault_o
);
  logic [LAG:0] dly_r;

  // The matrix answers late by LAG+1 cycles; requests lead the operate delay by 5 ms or more.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      dly_r <= '0;
    end else begin
      dly_r <= {dly_r[LAG-1:0], blk_req_i};
    end
  end
  assign block_o = dly_r[LAG];

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      evt_cnt_o <= 8'h00;
    end else if (evt_valid_i) begin
      evt_cnt_o    <= evt_cnt_o + 8'h01;
      last_code_o  <= evt_code_i;
      last_time_o  <= evt_time_i;
      last_fault_o <= evt_fault_i;
    end
  end
endmodule : psbel_partner

// file: tb_top.sv
`timescale 1ns/100ps
`include "psbel_defines.svh"

module tb_top;
  localparam int         CYC  = 20;
  // Stage six follows the two reserved codes, so its base is 6*6+2.
  localparam logic [6:0] BASE = 7'h26;
  logic        clk  = 1'b0;
  logic        rst  = 1'b1;
  logic        pu   = 1'b0;
  logic        blk  = 1'b0;
  logic        frc  = 1'b0;
  logic        wr   = 1'b0;
  logic        rd   = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wd   = 32'h0;
  logic [39:0] tms  = 40'h0;
  logic [3:0]  flt  = 4'h5;
  logic [2:0]  sg   = 3'h2;
  logic        bi, st, tr, ba, hmi, ev, irq;
  logic [31:0] rdat;
  logic [6:0]  code, lcode;
  logic [39:0] etime, ltime;
  logic [3:0]  efault, lfault;
  logic [7:0]  ecnt;
  logic [31:0] emag, erat, lmag, lrat;
  logic [2:0]  esg, lsg;
  int          n_mismatch  = 0;
  int          check_count = 0;
  int          cycles      = 0;

  psbel_top #(.CYCLE_CNT(CYC), .STAGE_IDX(6)) dut_u (
    .sys_clk_i(clk), .srst_i(rst), .pickup_i(pu), .block_i(bi),
    .stage_forcing_enable_i(frc), .time_ms_i(tms), .meas_mag_i(32'h1234),
    .mag_ratio_i(32'h0abc), .fault_type_i(flt), .active_setting_group_i(sg),
    .stage_start_o(st), .stage_trip_o(tr), .stage_a_o(ba), .hmi_block_o(hmi),
    .evt_valid_o(ev), .evt_code_o(code), .evt_time_o(etime), .evt_mag_o(emag),
    .evt_ratio_o(erat), .evt_fault_o(efault), .evt_sg_o(esg), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .irq_o(irq));

  psbel_partner #(.LAG(2)) bm_u (
    .sys_clk_i(clk), .srst_i(rst), .blk_req_i(blk), .block_o(bi), .evt_valid_i(ev),
    .evt_code_i(code), .evt_time_i(etime), .evt_fault_i(efault), .evt_cnt_o(ecnt),
    .last_code_o(lcode), .last_time_o(ltime), .last_fault_o(lfault));

  always #5 clk = ~clk;

  // Keeps the process data of the last stored event that the recorder model drops.
  always @(posedge clk) begin
    if (ev) begin
      lmag <= emag;
      lrat <= erat;
      lsg  <= esg;
    end
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch = n_mismatch + 1;
      conclude();
    end
  end

  task automatic conclude;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd   <= d;
    wr   <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrr

  // Read data stand only in the cycle after the strobe, so sample at the edge that ends it.
  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdat;
  endtask : rdr

  task automatic steps(input int n);
    repeat (n * CYC) @(posedge clk);
  endtask : steps

  task automatic evt(input logic [6:0] c);
    logic [7:0] n0;
    n0 = ecnt;
    for (int i = 0; i < 8 * CYC && ecnt === n0; i++) @(posedge clk);
    chk(ecnt, n0 + 8'h01);
    chk(lcode, c);
    chk(ltime, tms);
    chk(lmag, 32'h1234);
    chk(lrat, 32'h0abc);
    chk(lsg, sg);
    chk(lfault, flt);
  endtask : evt

  task automatic do_rst;
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
  endtask : do_rst

  task automatic cfg;
    wrr(`PSBEL_REG_OP_DLY, 32'h4);
    wrr(`PSBEL_REG_REL_DLY, 32'h2);
    wrr(`PSBEL_REG_IRQ_EN, 32'h7);
  endtask : cfg

  task automatic s_regs;
    logic [31:0] d;
    logic [7:0]  ra [5] = '{`PSBEL_REG_OP_DLY, `PSBEL_REG_REL_DLY, `PSBEL_REG_EVT_MASK,
                            `PSBEL_REG_IRQ_EN, 8'hfc};
    logic [31:0] rv [5] = '{32'h28, 32'h3c, 32'h3f, 32'h0, 32'h0};
    for (int i = 0; i < 5; i++) begin
      rdr(ra[i], d);
      chk(d, rv[i]);
    end
    cfg();
    rdr(`PSBEL_REG_OP_DLY, d);
    chk(d, 32'h4);
  endtask : s_regs

  task automatic s_trip;
    tms <= 40'h11;
    pu  <= 1'b1;
    evt(BASE);
    chk(st, 1'b1);
    evt(BASE + 7'h1);
    evt(BASE + 7'h2);
    chk(tr, 1'b1);
    chk(irq, 1'b1);
    pu <= 1'b0;
    evt(BASE + 7'h3);
    chk(tr, 1'b0);
    wrr(`PSBEL_REG_IRQ_CLR, 32'h7);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    steps(4);
  endtask : s_trip

  task automatic s_block_start;
    flt <= 4'h9;
    wrr(`PSBEL_REG_OP_DLY, 32'h10);
    pu <= 1'b1;
    evt(BASE);
    blk <= 1'b1;
    evt(BASE + 7'h1);
    chk(ba, 1'b0);
    evt(BASE + 7'h4);
    chk(ba, 1'b1);
    chk(lfault, 4'h9);
    pu <= 1'b0;
    evt(BASE + 7'h5);
    blk <= 1'b0;
    steps(2);
    wrr(`PSBEL_REG_OP_DLY, 32'h4);
  endtask : s_block_start

  task automatic s_block_idle;
    logic [31:0] d;
    logic [7:0]  n0;
    blk <= 1'b1;
    wrr(`PSBEL_REG_IRQ_CLR, 32'h7);
    wrr(`PSBEL_REG_IRQ_EN, 32'h3);
    pu <= 1'b1;
    evt(BASE + 7'h4);
    n0 = ecnt;
    steps(6);
    chk(ecnt, n0);
    chk(st, 1'b0);
    rdr(`PSBEL_REG_IRQ_STAT, d);
    chk(d[2], 1'b1);
    chk(irq, 1'b0);
    wrr(`PSBEL_REG_IRQ_EN, 32'h4);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    wrr(`PSBEL_REG_IRQ_CLR, 32'h4);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    pu <= 1'b0;
    evt(BASE + 7'h5);
    blk <= 1'b0;
  endtask : s_block_idle

  task automatic s_forcing;
    frc <= 1'b1;
    wrr(`PSBEL_REG_CTRL, 32'h1);
    pu <= 1'b1;
    evt(BASE + 7'h4);
    pu <= 1'b0;
    evt(BASE + 7'h5);
    wrr(`PSBEL_REG_CTRL, 32'h0);
    frc <= 1'b0;
  endtask : s_forcing

  task automatic s_mask;
    logic [7:0] n0;
    wrr(`PSBEL_REG_EVT_MASK, 32'h2);
    n0 = ecnt;
    pu <= 1'b1;
    steps(2);
    chk(st, 1'b1);
    chk(ecnt, n0);
    pu <= 1'b0;
    evt(BASE + 7'h1);
    wrr(`PSBEL_REG_EVT_MASK, 32'h3f);
    steps(4);
  endtask : s_mask

  // Thirteen records into twelve slots: the first one must be gone.
  task automatic s_history;
    logic [31:0] d;
    do_rst();
    sg <= 3'h6;
    cfg();
    for (int i = 0; i < 13; i++) begin
      tms <= 40'h100 + i;
      pu  <= 1'b1;
      evt(BASE);
      pu <= 1'b0;
      evt(BASE + 7'h1);
      steps(3);
      if (i == 0) begin
        rdr(`PSBEL_REG_STATUS, d);
        chk(d[19:16], 4'h1);
      end
    end
    rdr(`PSBEL_REG_STATUS, d);
    chk(d[19:16], 4'hc);
    wrr(`PSBEL_REG_HIST_SEL, 32'h0);
    rdr(`PSBEL_REG_HIST_W4, d);
    chk(d, 32'h101);
    rdr(`PSBEL_REG_HIST_W3, d);
    chk(d[6:0], BASE);
    rdr(`PSBEL_REG_HIST_W2, d);
    chk(d, 32'h1234);
    rdr(`PSBEL_REG_HIST_W1, d);
    chk(d, 32'h0abc);
    rdr(`PSBEL_REG_HIST_W0, d);
    chk(d[2:0], 3'h6);
    chk(d[23:3], 21'h4);
    wrr(`PSBEL_REG_HIST_SEL, 32'hf);
    rdr(`PSBEL_REG_HIST_W4, d);
    chk(d, 32'h10c);
  endtask : s_history

  initial begin
    do_rst();
    s_regs();
    s_trip();
    s_block_start();
    s_block_idle();
    s_forcing();
    s_mask();
    s_history();
    conclude();
  end
endmodule : tb_top
